// ### src/rffe_consts.svh
`ifndef RFFE_CONSTS_SVH
`define RFFE_CONSTS_SVH
// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RFFE_IDX_CTRL_ONE 8'h04
`define RFFE_IDX_ANT_DIV 8'h0D
`define RFFE_IDX_RF_CTRL0 8'h16
`define RFFE_IDX_STATUS 8'h20
`define RFFE_ADDR_W 12
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RFFE_FE_IND_EN_BIT 7
`define RFFE_TS_EN_BIT 6
`define RFFE_ANT_SEL_BIT 7
`define RFFE_AUTO_ANT_BIT 3
`define RFFE_SW_DRIVE_BIT 2
`define RFFE_PA_LEAD_TIME_HI 7
`define RFFE_PA_LEAD_TIME_LO 6
// ----------------------------------------------------------------
// reset values and static select codes
// ----------------------------------------------------------------
`define RFFE_CTRL_ONE_RST 8'h20
`define RFFE_ANT_DIV_RST 8'h00
`define RFFE_RF_CTRL0_RST 8'h00
`define RFFE_ANT_CODE_0 2'h1
`define RFFE_ANT_CODE_1 2'h2
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RFFE_CLK_NS 50
`define RFFE_SYMBOL_NS 16000
`define RFFE_LEAD_STEP_NS 2000
`define RFFE_SYM_CYC (`RFFE_SYMBOL_NS / `RFFE_CLK_NS)
`define RFFE_LEAD_STEP_CYC (`RFFE_LEAD_STEP_NS / `RFFE_CLK_NS)
`define RFFE_CNT_W 10
`endif

// ### src/rffe_pkg.sv
`default_nettype none
package rffe_pkg;
   // transceiver state as reported by the radio core
   typedef enum logic [2:0] {
      RFFE_OFF = 3'b000,
      RFFE_PLL_ON = 3'b001,
      RFFE_RX_ON = 3'b010,
      RFFE_BUSY_RX = 3'b011,
      RFFE_BUSY_TX = 3'b100,
      RFFE_SLEEP = 3'b101
   } rffe_state_type;

   // the four auxiliary output pins
   typedef struct packed {
      logic ant_switch_pin_a;
      logic ant_switch_pin_b;
      logic front_end_pin_a;
      logic front_end_pin_b;
   } rffe_pins_type;
endpackage
`default_nettype wire

// ### src/rffe_tx_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "rffe_consts.svh"
module rffe_tx_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sleep_tx_trigger,
   input wire rffe_pkg::rffe_state_type trx_state,
   input wire logic [1:0] pa_lead_time,
   output logic tx_start,
   output logic mod_start,
   output logic fe_tx_on
);
   import rffe_pkg::*;

   logic trig_prev_reg;
   logic active_reg;
   logic run_reg;
   logic fe_reg;
   logic [`RFFE_CNT_W-1:0] cnt_reg;
   wire [`RFFE_CNT_W-1:0] sym_cyc = `RFFE_CNT_W'(`RFFE_SYM_CYC);
   wire [`RFFE_CNT_W-1:0] lead_cyc;
   wire [`RFFE_CNT_W-1:0] threshold;
   wire fe_next;

   assign tx_start = sleep_tx_trigger && !trig_prev_reg && trx_state == RFFE_PLL_ON;
   assign mod_start = active_reg && cnt_reg == sym_cyc - `RFFE_CNT_W'(1);
   assign lead_cyc = `RFFE_CNT_W'(`RFFE_LEAD_STEP_CYC) * `RFFE_CNT_W'({1'b0, pa_lead_time} + 3'h1);
   assign threshold = sym_cyc - lead_cyc;
   // after modulation start, leaving busy-tx drops the indicator one edge later, whatever the lead; before it the lead window runs on
   assign fe_next = (active_reg && cnt_reg >= threshold) || (run_reg && trx_state == RFFE_BUSY_TX);
   assign fe_tx_on = fe_reg;

   // -------------------------------------------------------------
   // symbol counter from the trigger edge to modulation start
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_prev_reg <= 1'b0;
         active_reg <= 1'b0;
         run_reg <= 1'b0;
         fe_reg <= 1'b0;
         cnt_reg <= '0;
      end else begin
         trig_prev_reg <= sleep_tx_trigger;
         fe_reg <= fe_next;
         if (tx_start) begin
            active_reg <= 1'b1;
            cnt_reg <= `RFFE_CNT_W'(1);
         end else if (mod_start) begin
            active_reg <= 1'b0;
            cnt_reg <= '0;
         end else if (active_reg) begin
            cnt_reg <= cnt_reg + `RFFE_CNT_W'(1);
         end
         if (mod_start) begin
            run_reg <= 1'b1;
         end else if (trx_state != RFFE_BUSY_TX) begin
            run_reg <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ### src/rffe_pin_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "rffe_consts.svh"
module rffe_pin_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`RFFE_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire rffe_pkg::rffe_state_type trx_state,
   input wire logic auto_retry_tx_mode,
   input wire logic auto_antenna_choice,
   input wire logic rx_start_event,
   input wire logic rx_end_event,
   input wire logic sleep_tx_trigger,
   output logic tx_start,
   output logic mod_start,
   output rffe_pkg::rffe_pins_type pins
);
   import rffe_pkg::*;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] ctrl_one_reg;
   logic [7:0] ant_div_reg;
   logic [7:0] rf_ctrl0_reg;
   logic [1:0] ant_applied_reg;
   logic ant_sel_reg;
   logic stamp_reg;
   logic [31:0] prdata_reg;
   rffe_pins_type pins_reg;
   rffe_pins_type pins_next;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   function automatic logic [`RFFE_ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = `RFFE_ADDR_W'({idx, 2'b00});
   endfunction

   wire sel_ctrl = paddr == reg_addr(`RFFE_IDX_CTRL_ONE);
   wire sel_ant = paddr == reg_addr(`RFFE_IDX_ANT_DIV);
   wire sel_rf = paddr == reg_addr(`RFFE_IDX_RF_CTRL0);
   wire sel_stat = paddr == reg_addr(`RFFE_IDX_STATUS);
   wire mapped = sel_ctrl || sel_ant || sel_rf || sel_stat;
   wire setup = psel && !penable;
   wire wr_go = psel && penable && pwrite && pstrb[0] && mapped;

   // zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_reg;

   // ----------------------------------------------------------------
   // field views
   // ----------------------------------------------------------------
   wire fe_ind_en = ctrl_one_reg[`RFFE_FE_IND_EN_BIT];
   wire ts_en = ctrl_one_reg[`RFFE_TS_EN_BIT];
   wire auto_ant_en = ant_div_reg[`RFFE_AUTO_ANT_BIT];
   wire sw_drive_en = ant_div_reg[`RFFE_SW_DRIVE_BIT];
   wire [1:0] static_select = ant_div_reg[1:0];
   wire [1:0] pa_lead_time = rf_ctrl0_reg[`RFFE_PA_LEAD_TIME_HI:`RFFE_PA_LEAD_TIME_LO];
   wire fe_tx_on;

   // ----------------------------------------------------------------
   // antenna selection
   // ----------------------------------------------------------------
   // apply only when settled
   wire ant_apply = trx_state == RFFE_PLL_ON || trx_state == RFFE_RX_ON;
   wire auto_pick = auto_ant_en && auto_retry_tx_mode;
   wire static_valid = ant_applied_reg == `RFFE_ANT_CODE_0 || ant_applied_reg == `RFFE_ANT_CODE_1;
   wire static_ant = ant_applied_reg == `RFFE_ANT_CODE_1;
   wire antenna = auto_pick ? auto_antenna_choice : static_ant;
   // reserved static codes leave the switch undriven, pin a low and pin b low unless stamping
   wire ant_drive = auto_pick || static_valid;
   wire ant_event = rx_start_event || rx_end_event || tx_start;

   // ----------------------------------------------------------------
   // pin multiplexing
   // ----------------------------------------------------------------
   always_comb begin
      pins_next = '0;
      if (sw_drive_en && ant_drive) begin
         pins_next.ant_switch_pin_a = antenna;
         pins_next.ant_switch_pin_b = !antenna;
      end
      if (ts_en) begin
         pins_next.ant_switch_pin_b = stamp_reg;
      end else if (!sw_drive_en) begin
         pins_next.ant_switch_pin_b = 1'b0;
      end
      if (fe_ind_en) begin
         pins_next.front_end_pin_a = fe_tx_on;
         pins_next.front_end_pin_b = !fe_tx_on;
      end
   end

   assign pins = pins_reg;

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   // control and status register read layout
   wire [7:0] ant_div_view = {ant_sel_reg, ant_div_reg[6:0]};
   wire [7:0] status_view = {stamp_reg, fe_tx_on, ant_applied_reg, 1'b0, trx_state};
   wire [7:0] rd_byte = sel_ctrl ? ctrl_one_reg :
                        sel_ant ? ant_div_view :
                        sel_rf ? rf_ctrl0_reg :
                        sel_stat ? status_view : 8'h00;

   // ----------------------------------------------------------------
   // register writes and read capture
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_one_reg <= `RFFE_CTRL_ONE_RST;
         ant_div_reg <= `RFFE_ANT_DIV_RST;
         rf_ctrl0_reg <= `RFFE_RF_CTRL0_RST;
         prdata_reg <= 32'h0000_0000;
      end else begin
         if (wr_go && sel_ctrl) begin
            ctrl_one_reg <= pwdata[7:0];
         end
         // antenna status bit is read-only
         if (wr_go && sel_ant) begin
            ant_div_reg <= {1'b0, pwdata[6:0]};
         end
         if (wr_go && sel_rf) begin
            rf_ctrl0_reg <= pwdata[7:0];
         end
         if (setup && !pwrite) begin
            prdata_reg <= {24'h00_0000, rd_byte};
         end
      end
   end

   // ----------------------------------------------------------------
   // antenna latch, stamp flag and pins
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ant_applied_reg <= 2'h0;
         ant_sel_reg <= 1'b0;
         stamp_reg <= 1'b0;
         pins_reg <= '0;
      end else begin
         pins_reg <= pins_next;
         if (ant_apply) begin
            ant_applied_reg <= static_select;
         end
         if (ant_event) begin
            ant_sel_reg <= antenna;
         end
         // fall at receive end; a new start wins
         if (ts_en && rx_start_event) begin
            stamp_reg <= 1'b1;
         end else if (rx_end_event || !ts_en) begin
            stamp_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // transmit timing
   // ----------------------------------------------------------------
   rffe_tx_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .sleep_tx_trigger(sleep_tx_trigger),
      .trx_state(trx_state),
      .pa_lead_time(pa_lead_time),
      .tx_start(tx_start),
      .mod_start(mod_start),
      .fe_tx_on(fe_tx_on)
   );

   // ----------------------------------------------------------------
   // check helper: cycles since the last transmit start
   // ----------------------------------------------------------------
   // counted apart from the timer so the timer's own count is checked;
   // it saturates so a long idle spell never wraps back onto a match
   logic [`RFFE_CNT_W-1:0] sym_chk_reg;
   wire sym_chk_run = sym_chk_reg != '0 && sym_chk_reg != '1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sym_chk_reg <= '0;
      end else if (tx_start) begin
         sym_chk_reg <= `RFFE_CNT_W'(1);
      end else if (sym_chk_run) begin
         sym_chk_reg <= sym_chk_reg + `RFFE_CNT_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_sw_off_ground: assert property (!sw_drive_en && !ts_en |=>
      !pins.ant_switch_pin_a && !pins.ant_switch_pin_b)
      else $error("antenna pins not grounded");
   a_diff_drive: assert property (sw_drive_en && !ts_en && ant_drive |=>
      pins.ant_switch_pin_a != pins.ant_switch_pin_b)
      else $error("antenna pair not differential");
   a_static_code: assert property (sw_drive_en && !ts_en && !auto_pick &&
      ant_applied_reg == `RFFE_ANT_CODE_0 |=> !pins.ant_switch_pin_a && pins.ant_switch_pin_b)
      else $error("static code 1 wrong pins");
   a_auto_follow: assert property (sw_drive_en && auto_pick |=>
      pins.ant_switch_pin_a == $past(auto_antenna_choice))
      else $error("auto antenna not followed");
   a_apply_hold: assert property (!ant_apply |=> $stable(ant_applied_reg))
      else $error("static select applied outside settled state");
   a_fe_disabled: assert property (!fe_ind_en |=>
      !pins.front_end_pin_a && !pins.front_end_pin_b)
      else $error("indicator pins not low");
   a_fe_tx_rev: assert property (fe_ind_en && fe_tx_on |=>
      pins.front_end_pin_a && !pins.front_end_pin_b)
      else $error("indicator not reversed in tx");
   a_mod_delay: assert property (sym_chk_reg == `RFFE_CNT_W'(`RFFE_SYM_CYC - 1) |->
      mod_start)
      else $error("modulation not one symbol after trigger");
   a_mod_only_sym: assert property (mod_start |->
      sym_chk_reg == `RFFE_CNT_W'(`RFFE_SYM_CYC - 1))
      else $error("modulation started off the symbol boundary");
   a_stamp_rise: assert property (ts_en && rx_start_event |=> stamp_reg ##1
      pins.ant_switch_pin_b)
      else $error("stamp pin did not rise");
   a_stamp_fall: assert property (rx_end_event && !rx_start_event |=> !stamp_reg)
      else $error("stamp pin did not fall");
   a_fe_lead: assert property ($rose(fe_tx_on) && pa_lead_time == 2'h3 |->
      sym_chk_reg == `RFFE_CNT_W'(`RFFE_SYM_CYC - 4 * `RFFE_LEAD_STEP_CYC + 1))
      else $error("indicator rose off the lead window");

   a_stamp_on_b: assert property (ts_en |=>
      pins.ant_switch_pin_b == $past(stamp_reg))
      else $error("pin b not carrying the stamp");
   a_pin_b_ground: assert property (!ts_en && !(sw_drive_en && ant_drive) |=>
      !pins.ant_switch_pin_b)
      else $error("unused pin b not grounded");
   a_fe_idle_pair: assert property (fe_ind_en && !fe_tx_on |=>
      !pins.front_end_pin_a && pins.front_end_pin_b)
      else $error("indicator idle pair wrong");
   a_static_code_2: assert property (sw_drive_en && !ts_en && !auto_pick &&
      ant_applied_reg == `RFFE_ANT_CODE_1 |=> pins.ant_switch_pin_a && !pins.ant_switch_pin_b)
      else $error("static code 2 wrong pins");
   a_reserved_idle: assert property (sw_drive_en && !auto_pick && !static_valid |=>
      !pins.ant_switch_pin_a)
      else $error("reserved static code drove pin a");
   a_stamp_gated: assert property (rx_start_event && !ts_en |=> !stamp_reg)
      else $error("stamp set while stamping disabled");

   c_tx_frame: cover property (tx_start ##[1:400] mod_start);
   c_stamp: cover property (ts_en && rx_start_event ##[1:1000] rx_end_event);
   c_auto_ant: cover property (sw_drive_en && auto_pick && auto_antenna_choice);
   c_static_1: cover property (sw_drive_en && ant_applied_reg == `RFFE_ANT_CODE_1);
   c_fe_lead3: cover property (tx_start && pa_lead_time == 2'h3);
endmodule
`default_nettype wire

// ### verification/rffe_far_side_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// far side: external pa and host capture timer
// ----------------------------------------------------------------
module rffe_far_side_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire rffe_pkg::rffe_pins_type pins,
   output logic pa_on,
   output logic [31:0] cyc_cnt,
   output logic [31:0] pa_rise_cyc,
   output logic [31:0] stamp_cyc
);
   import rffe_pkg::*;
   logic pa_on_reg;
   logic stamp_reg;
   // pa powers only on the tx pair
   assign pa_on = pins.front_end_pin_a & ~pins.front_end_pin_b;
   // cycle count plus capture of pa and stamp rises, like a timer unit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_cnt <= '0;
         pa_on_reg <= 1'b0;
         stamp_reg <= 1'b0;
         pa_rise_cyc <= '0;
         stamp_cyc <= '0;
      end else begin
         cyc_cnt <= cyc_cnt + 32'h1;
         pa_on_reg <= pa_on;
         stamp_reg <= pins.ant_switch_pin_b;
         if (pa_on && !pa_on_reg) pa_rise_cyc <= cyc_cnt;
         if (pins.ant_switch_pin_b && !stamp_reg) stamp_cyc <= cyc_cnt;
      end
   end
endmodule
`default_nettype wire

// ### verification/rffe_pin_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "rffe_consts.svh"
// ----------------------------------------------------------------
// bench for the auxiliary pin controller
// ----------------------------------------------------------------
module rffe_pin_ctrl_tb;
   import rffe_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic rxs, rxe, trig, aretry, achoice, tx_start, mod_start, pa_on;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, cyc, pa_cyc, st_cyc, t0, t1;
   logic [3:0] pstrb;
   rffe_state_type st;
   rffe_pins_type pins;
   int error_cnt = 0;
   int n_checks = 0;
   localparam logic [11:0] A_CTRL = 12'(`RFFE_IDX_CTRL_ONE * 4);
   localparam logic [11:0] A_DIV = 12'(`RFFE_IDX_ANT_DIV * 4);
   localparam logic [11:0] A_RF = 12'(`RFFE_IDX_RF_CTRL0 * 4);
   always #25 pclk = ~pclk;
   rffe_pin_ctrl rffe_pin_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .trx_state(st),
      .auto_retry_tx_mode(aretry), .auto_antenna_choice(achoice), .rx_start_event(rxs),
      .rx_end_event(rxe), .sleep_tx_trigger(trig), .tx_start(tx_start),
      .mod_start(mod_start), .pins(pins));
   rffe_far_side_model rffe_far_side_model_inst (.pclk(pclk), .presetn(presetn),
      .pins(pins), .pa_on(pa_on), .cyc_cnt(cyc), .pa_rise_cyc(pa_cyc), .stamp_cyc(st_cyc));
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // pins settle within two edges after any input or register change
   task automatic pchk(input string what, input logic [3:0] exp);
      tick(3);
      chk(what, {28'h0, exp}, {28'h0, pins});
   endtask
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 16);
      if (i >= 16) begin
         error_cnt++;
         wrap_up();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         // one idle edge, so a following setup never reassigns psel in this step
         @(posedge pclk);
      end
   endtask
   task automatic wait_hi(input logic m, output logic [31:0] t);
      int i;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while ((m ? mod_start : tx_start) !== 1'b1 && i < 500);
      t = cyc;
      if (i >= 500) begin
         error_cnt++;
         wrap_up();
      end
   endtask
   task automatic t_regs;
      chk("pins after reset", 32'h0, {28'h0, pins});
      apb(1'b0, A_CTRL, 8'h00);
      chk("ctrl reset", 32'h20, rd);
      apb(1'b0, A_DIV, 8'h00);
      chk("ant_div reset", 32'h0, rd);
      apb(1'b1, A_CTRL, 8'hDF);
      apb(1'b0, A_CTRL, 8'h00);
      chk("ctrl rw", 32'hDF, rd);
      apb(1'b1, A_CTRL, 8'h20);
      apb(1'b0, 12'hFFC, 8'h00);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      $display("test regs done");
   endtask
   task automatic t_static;
      logic [3:0] ex [4] = '{4'h0, 4'h4, 4'h8, 4'h0};
      st <= RFFE_RX_ON;
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, A_DIV, 8'h04 | 8'(c));
         pchk("static code", ex[c]);
      end
      apb(1'b1, A_DIV, 8'h05);
      st <= RFFE_OFF;
      apb(1'b1, A_DIV, 8'h06);
      pchk("held in off", 4'h4);
      st <= RFFE_PLL_ON;
      pchk("applied in pll", 4'h8);
      st <= RFFE_SLEEP;
      apb(1'b1, A_DIV, 8'h0E);
      pchk("active in sleep", 4'h8);
      apb(1'b1, A_DIV, 8'h02);
      pchk("drive off", 4'h0);
      $display("test static done");
   endtask
   task automatic t_auto;
      st <= RFFE_BUSY_TX;
      aretry <= 1'b1;
      achoice <= 1'b0;
      apb(1'b1, A_DIV, 8'h0D);
      pchk("auto ant0", 4'h4);
      achoice <= 1'b1;
      pchk("auto ant1", 4'h8);
      // leaving aret in rx-on lets the written code 1 reach the pins
      aretry <= 1'b0;
      st <= RFFE_RX_ON;
      pchk("static outside aret", 4'h4);
      $display("test auto done");
   endtask
   task automatic t_stamp;
      apb(1'b1, A_DIV, 8'h0C);
      apb(1'b1, A_CTRL, 8'h60);
      st <= RFFE_BUSY_RX;
      aretry <= 1'b1;
      pchk("stamp idle", 4'h8);
      rxs <= 1'b1;
      t0 = cyc;
      tick(1);
      rxs <= 1'b0;
      pchk("stamp high", 4'hC);
      chk("stamp time", t0 + 32'h3, st_cyc);
      tick(20);
      chk("stamp held", 32'hC, {28'h0, pins});
      rxe <= 1'b1;
      tick(1);
      rxe <= 1'b0;
      pchk("stamp end", 4'h8);
      apb(1'b1, A_DIV, 8'h00);
      rxs <= 1'b1;
      tick(1);
      rxs <= 1'b0;
      pchk("stamp no drive", 4'h4);
      apb(1'b1, A_CTRL, 8'h20);
      pchk("pin b grounded", 4'h0);
      $display("test stamp done");
   endtask
   task automatic t_front;
      apb(1'b1, A_CTRL, 8'hA0);
      st <= RFFE_RX_ON;
      pchk("fe rx pair", 4'h1);
      trig <= 1'b1;
      tick(1);
      chk("no start off pll", 32'h0, {31'h0, tx_start});
      for (int lt = 0; lt < 4; lt++) begin
         trig <= 1'b0;
         st <= RFFE_PLL_ON;
         apb(1'b1, A_RF, 8'(lt << 6));
         trig <= 1'b1;
         wait_hi(1'b0, t0);
         st <= RFFE_BUSY_TX;
         wait_hi(1'b1, t1);
         chk("mod delay", 32'd319, t1 - t0);
         chk("pa lead", 32'h1, {31'h0, (t1 - pa_cyc) inside {[37 + 40 * lt : 40 + 40 * lt]}});
         pchk("fe tx pair", 4'h2);
         st <= RFFE_PLL_ON;
         pchk("fe back", 4'h1);
      end
      apb(1'b1, A_CTRL, 8'h20);
      pchk("fe disabled", 4'h0);
      $display("test front done");
   endtask
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      st = RFFE_OFF;
      {rxs, rxe, trig, aretry, achoice} = 5'h00;
      tick(2);
      presetn <= 1'b1;
      tick(1);
      t_regs();
      t_static();
      t_auto();
      t_stamp();
      t_front();
      st <= RFFE_SLEEP;
      tick(2);
      wrap_up();
   end
endmodule
`default_nettype wire
